// >>> rtl/serial_config_port_ref_lock.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_config_port_ref_lock_cfg.svh"

module serial_config_port_ref_lock
	import serial_config_port_ref_lock_pkg::*;
#(
	parameter int FREQ_ERR_W = 16
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  reset_n_i,
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	output logic                       sda_o,
	output logic                       sda_oe_n_o,
	input  wire logic                  address_select_pin_i,
	input  wire logic [FREQ_ERR_W-1:0] freq_error_ppm_i,
	output logic                       lock_to_ref_o,
	output logic                       fine_meas_en_o,
	output logic [1:0]                 ref_range_o,
	output logic [3:0]                 ref_ratio_o,
	output logic                       lock_cmd_o,
	output logic                       reacquire_o,
	output logic                       harmonic_det_en_o,
	output logic                       loss_of_lock_flag_o
);

	// ==========================================================
	// parameter check
	// refused at elaboration: a narrow port would wrap the exit threshold
	if (FREQ_ERR_W < 11 || FREQ_ERR_W > 31) begin : g_bad_err_width
		$error("FREQ_ERR_W must hold the exit threshold");
	end

	// ==========================================================
	// reset release
	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// ==========================================================
	// pin synchronisers and edge finding
	logic scl_s1_reg;
	logic scl_s2_reg;
	logic scl_d_reg;
	logic sda_s1_reg;
	logic sda_s2_reg;
	logic sda_d_reg;
	logic sel_s1_reg;
	logic sel_s2_reg;

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			scl_s1_reg <= 1'b1;
			scl_s2_reg <= 1'b1;
			scl_d_reg  <= 1'b1;
			sda_s1_reg <= 1'b1;
			sda_s2_reg <= 1'b1;
			sda_d_reg  <= 1'b1;
			sel_s1_reg <= 1'b0;
			sel_s2_reg <= 1'b0;
		end else begin
			scl_s1_reg <= scl_i;
			scl_s2_reg <= scl_s1_reg;
			scl_d_reg  <= scl_s2_reg;
			sda_s1_reg <= sda_i;
			sda_s2_reg <= sda_s1_reg;
			sda_d_reg  <= sda_s2_reg;
			sel_s1_reg <= address_select_pin_i;
			sel_s2_reg <= sel_s1_reg;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	assign scl_rise   = scl_s2_reg & ~scl_d_reg;
	assign scl_fall   = ~scl_s2_reg & scl_d_reg;
	// scl must be high before and after the sda edge, so an scl edge is never misread
	assign start_seen = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
	assign stop_seen  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

	// ==========================================================
	// register file
	logic [7:0]           ref_ctrl_reg;
	logic [7:0]           scratch_reg [`NUM_SUBADDR];
	logic [`SUBADDR_W-1:0] ptr_reg;
	logic                 lol_reg;

	function automatic logic [7:0] read_byte(input logic [`SUBADDR_W-1:0] idx);
		logic [7:0] val;
		val = scratch_reg[idx];
		if (idx == `REF_CTRL_SUBADDR) begin
			val = ref_ctrl_reg;
		end else if (idx == `STATUS_SUBADDR) begin
			val = 8'h00;
			val[`STAT_LOL_BIT]      = lol_reg;
			val[`STAT_CONFLICT_BIT] = ref_ctrl_reg[`LOCK_REF_BIT] &
				ref_ctrl_reg[`FINE_MEAS_BIT];
		end
		return val;
	endfunction

	function automatic logic [`SUBADDR_W-1:0] next_ptr(input logic [`SUBADDR_W-1:0] idx);
		// reads and writes saturate at the top address
		return (idx == `LAST_SUBADDR) ? idx : idx + 3'h1;
	endfunction

	// always_comb, unlike assign, also wakes on registers read inside the function
	logic [7:0] rd_cur_byte;
	logic [7:0] rd_nxt_byte;

	always_comb begin
		rd_cur_byte = read_byte(ptr_reg);
		rd_nxt_byte = read_byte(next_ptr(ptr_reg));
	end

	// ==========================================================
	// serial protocol engine
	port_state_t state_reg;
	logic [3:0]  bit_cnt_reg;
	logic [7:0]  shift_reg;
	logic        rw_reg;
	logic        nack_reg;
	logic        drive_reg;
	logic        commit_pulse;
	logic [7:0]  commit_data;
	logic [`SUBADDR_W-1:0] commit_idx;
	logic [6:0]  own_addr;

	assign own_addr = {`SLV_ADDR_MSB_VAL, sel_s2_reg, `SLV_ADDR_LOW_VAL};

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg    <= ST_IDLE;
			bit_cnt_reg  <= `BIT_CNT_ZERO;
			shift_reg    <= 8'h00;
			rw_reg       <= 1'b0;
			nack_reg     <= 1'b0;
			drive_reg    <= 1'b0;
			ptr_reg      <= `REF_CTRL_SUBADDR;
			commit_pulse <= 1'b0;
			commit_data  <= 8'h00;
			commit_idx   <= `REF_CTRL_SUBADDR;
		end else begin
			commit_pulse <= 1'b0;
			if (stop_seen) begin
				state_reg <= ST_IDLE;
				drive_reg <= 1'b0;
			end else if (start_seen) begin
				// a start in any state restarts address reception
				state_reg   <= ST_ADDR;
				bit_cnt_reg <= `BIT_CNT_ZERO;
				drive_reg   <= 1'b0;
			end else begin
				case (state_reg)
					ST_ADDR, ST_SUB, ST_WR: begin
						if (scl_rise && bit_cnt_reg != `BITS_PER_BYTE) begin
							shift_reg   <= {shift_reg[6:0], sda_s2_reg};
							bit_cnt_reg <= bit_cnt_reg + `BIT_CNT_ONE;
						end else if (scl_fall && bit_cnt_reg == `BITS_PER_BYTE) begin
							bit_cnt_reg <= `BIT_CNT_ZERO;
							if (state_reg == ST_ADDR) begin
								if (shift_reg[7:1] == own_addr) begin
									rw_reg    <= shift_reg[0];
									drive_reg <= 1'b1;
									state_reg <= ST_ADDR_AK;
								end else begin
									state_reg <= ST_IDLE;
								end
							end else if (state_reg == ST_SUB) begin
								if (shift_reg[7:3] == `SUBADDR_HIGH_ZERO) begin
									ptr_reg   <= shift_reg[2:0];
									drive_reg <= 1'b1;
									state_reg <= ST_SUB_AK;
								end else begin
									state_reg <= ST_IDLE;
								end
							end else begin
								commit_pulse <= 1'b1;
								commit_data  <= shift_reg;
								commit_idx   <= ptr_reg;
								ptr_reg      <= next_ptr(ptr_reg);
								drive_reg    <= 1'b1;
								state_reg    <= ST_WR_AK;
							end
						end
					end
					ST_ADDR_AK, ST_SUB_AK, ST_WR_AK: begin
						if (scl_fall) begin
							if (state_reg == ST_ADDR_AK && rw_reg == `RW_READ) begin
								shift_reg <= rd_cur_byte;
								drive_reg <= ~rd_cur_byte[7];
								state_reg <= ST_RD;
							end else begin
								drive_reg <= 1'b0;
								state_reg <= (state_reg == ST_ADDR_AK) ? ST_SUB : ST_WR;
							end
						end
					end
					ST_RD: begin
						if (scl_rise) begin
							bit_cnt_reg <= bit_cnt_reg + `BIT_CNT_ONE;
						end else if (scl_fall) begin
							if (bit_cnt_reg == `BITS_PER_BYTE) begin
								drive_reg   <= 1'b0;
								bit_cnt_reg <= `BIT_CNT_ZERO;
								state_reg   <= ST_RD_AK;
							end else begin
								shift_reg <= {shift_reg[6:0], 1'b0};
								drive_reg <= ~shift_reg[6];
							end
						end
					end
					ST_RD_AK: begin
						if (scl_rise) begin
							nack_reg <= sda_s2_reg;
						end else if (scl_fall) begin
							if (nack_reg) begin
								state_reg <= ST_IDLE;
							end else begin
								ptr_reg   <= next_ptr(ptr_reg);
								shift_reg <= rd_nxt_byte;
								drive_reg <= ~rd_nxt_byte[7];
								state_reg <= ST_RD;
							end
						end
					end
					ST_IDLE: begin
						drive_reg <= 1'b0;
					end
					default: begin
						state_reg <= ST_IDLE;
						drive_reg <= 1'b0;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// pin drive: open drain, enable low while pulling low
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sda_o      <= 1'b0;
			sda_oe_n_o <= 1'b1;
		end else begin
			sda_o      <= 1'b0;
			sda_oe_n_o <= ~drive_reg;
		end
	end

	// ==========================================================
	// register commit
	logic lock_cmd_next;

	assign lock_cmd_next = commit_pulse && commit_idx == `REF_CTRL_SUBADDR &&
		commit_data[`LOCK_REF_BIT] && !ref_ctrl_reg[`LOCK_REF_BIT];

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ref_ctrl_reg <= `REF_CTRL_RESET;
			lock_cmd_o   <= 1'b0;
		end else begin
			lock_cmd_o <= lock_cmd_next;
			if (commit_pulse && commit_idx == `REF_CTRL_SUBADDR) begin
				ref_ctrl_reg <= commit_data;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `NUM_SUBADDR; i++) begin
				scratch_reg[i] <= `SCRATCH_RESET;
			end
		end else if (commit_pulse && commit_idx != `REF_CTRL_SUBADDR &&
			commit_idx != `STATUS_SUBADDR) begin
			scratch_reg[commit_idx] <= commit_data;
		end
	end

	// ==========================================================
	// control outputs toward the recovery loop
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lock_to_ref_o     <= 1'b0;
			fine_meas_en_o    <= 1'b0;
			ref_range_o       <= 2'h0;
			ref_ratio_o       <= 4'h0;
			harmonic_det_en_o <= 1'b1;
		end else begin
			lock_to_ref_o     <= ref_ctrl_reg[`LOCK_REF_BIT];
			fine_meas_en_o    <= ref_ctrl_reg[`FINE_MEAS_BIT];
			ref_range_o       <= ref_ctrl_reg[`RANGE_MSB:`RANGE_LSB];
			// exponents above the top ratio are clamped to it
			ref_ratio_o       <= (ref_ctrl_reg[`RATIO_MSB:`RATIO_LSB] > `RATIO_MAX) ?
				`RATIO_MAX : ref_ctrl_reg[`RATIO_MSB:`RATIO_LSB];
			harmonic_det_en_o <= ~ref_ctrl_reg[`LOCK_REF_BIT];
		end
	end

	// ==========================================================
	// lock indication with hysteresis
	localparam logic [FREQ_ERR_W-1:0] ENTER_PPM = FREQ_ERR_W'(`LOCK_ENTER_PPM);
	localparam logic [FREQ_ERR_W-1:0] EXIT_PPM  = FREQ_ERR_W'(`LOCK_EXIT_PPM);

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lol_reg             <= 1'b1;
			loss_of_lock_flag_o <= 1'b1;
			reacquire_o         <= 1'b0;
		end else begin
			reacquire_o <= 1'b0;
			if (lock_cmd_next) begin
				// a new lock command always starts from unlocked
				lol_reg     <= 1'b1;
				reacquire_o <= 1'b1;
			end else if (!lol_reg && freq_error_ppm_i > EXIT_PPM) begin
				lol_reg     <= 1'b1;
				reacquire_o <= ref_ctrl_reg[`LOCK_REF_BIT];
			end else if (lol_reg && freq_error_ppm_i <= ENTER_PPM) begin
				lol_reg <= 1'b0;
			end
			loss_of_lock_flag_o <= lol_reg;
		end
	end

endmodule

`default_nettype wire

// >>> shared/serial_config_port_ref_lock_cfg.svh
`ifndef SERIAL_CONFIG_PORT_REF_LOCK_CFG_SVH
`define SERIAL_CONFIG_PORT_REF_LOCK_CFG_SVH

// ==========================================================
// slave address layout
`define SLV_ADDR_MSB_VAL     1'b1
`define SLV_ADDR_LOW_VAL     5'h00
`define RW_READ              1'b1

// ==========================================================
// subaddress map
`define NUM_SUBADDR          8
`define SUBADDR_W            3
`define REF_CTRL_SUBADDR     3'h0
`define STATUS_SUBADDR       3'h1
`define LAST_SUBADDR         3'h7
`define SUBADDR_HIGH_ZERO    5'h00

// ==========================================================
// reference control fields and reset value
`define REF_CTRL_RESET       8'h00
`define SCRATCH_RESET        8'h00
`define LOCK_REF_BIT         0
`define FINE_MEAS_BIT        1
`define RATIO_LSB            2
`define RATIO_MSB            5
`define RANGE_LSB            6
`define RANGE_MSB            7
`define RATIO_MAX            4'h8

// ==========================================================
// status byte fields
`define STAT_LOL_BIT         0
`define STAT_CONFLICT_BIT    1

// ==========================================================
// lock hysteresis thresholds in ppm
`define LOCK_ENTER_PPM       250
`define LOCK_EXIT_PPM        1000

// ==========================================================
// bit counting
`define BITS_PER_BYTE        4'h8
`define BIT_CNT_ZERO         4'h0
`define BIT_CNT_ONE          4'h1

`endif

// >>> shared/serial_config_port_ref_lock_pkg.sv
package serial_config_port_ref_lock_pkg;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h0,
		ST_ADDR    = 4'h1,
		ST_ADDR_AK = 4'h2,
		ST_SUB     = 4'h3,
		ST_SUB_AK  = 4'h4,
		ST_WR      = 4'h5,
		ST_WR_AK   = 4'h6,
		ST_RD      = 4'h7,
		ST_RD_AK   = 4'h8
	} port_state_t;

endpackage

// >>> bench/serial_config_port_ref_lock_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_config_port_ref_lock_cfg.svh"

module serial_config_port_ref_lock_sva #(
	parameter int FREQ_ERR_W = 16
) (
	input wire logic                  core_clk_i,
	input wire logic                  reset_n_i,
	input wire logic                  scl_i,
	input wire logic                  sda_o,
	input wire logic                  sda_oe_n_o,
	input wire logic [FREQ_ERR_W-1:0] freq_error_ppm_i,
	input wire logic                  lock_to_ref_o,
	input wire logic [3:0]            ref_ratio_o,
	input wire logic                  lock_cmd_o,
	input wire logic                  reacquire_o,
	input wire logic                  harmonic_det_en_o,
	input wire logic                  loss_of_lock_flag_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	// ==================
	// serial port
	a_sda_zero: assert property (sda_o == 1'b0)
		else $error("sda data not low");
	// enable moves only a few cycles after an scl fall
	a_oe_on_low: assert property ($changed(sda_oe_n_o) |-> $past(scl_i, 4) == 1'b0)
		else $error("sda enable moved late in scl high");

	// ==================
	// reference control
	a_ratio_max: assert property (ref_ratio_o <= `RATIO_MAX)
		else $error("ratio above maximum");
	a_harm_off: assert property (harmonic_det_en_o == !lock_to_ref_o)
		else $error("harmonic detector does not follow reference mode");
	a_cmd_pulse: assert property (lock_cmd_o |=> !lock_cmd_o)
		else $error("lock command longer than one cycle");
	a_cmd_mode: assert property (lock_cmd_o |-> ##[0:3] lock_to_ref_o)
		else $error("lock command without reference mode");
	a_cmd_reacq: assert property (lock_cmd_o |-> ##[0:2] reacquire_o)
		else $error("lock command without reacquire");

	// ==================
	// lock hysteresis
	a_lol_set: assert property (
		(freq_error_ppm_i > `LOCK_EXIT_PPM)[*3] |-> loss_of_lock_flag_o)
		else $error("loss of lock not set");
	// a fresh lock command sets the flag, so windows exclude it
	a_lol_clr: assert property (
		(freq_error_ppm_i <= `LOCK_ENTER_PPM && !lock_cmd_o)[*6] |-> !loss_of_lock_flag_o)
		else $error("loss of lock not cleared");
endmodule

`default_nettype wire

// >>> bench/two_wire_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module two_wire_master_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	// ==================
	// idle: clock parked high, data released
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// quarter of the 160 ns serial period
	task automatic qtr();
		repeat (4) @(negedge clk_i);
	endtask

	// also a repeated start; one event per high phase
	task automatic start();
		sda_low_o = 1'b0;
		qtr();
		scl_o = 1'b1;
		qtr();
		sda_low_o = 1'b1;
		qtr();
		scl_o = 1'b0;
		qtr();
	endtask

	task automatic stop();
		sda_low_o = 1'b1;
		qtr();
		scl_o = 1'b1;
		qtr();
		sda_low_o = 1'b0;
		qtr();
	endtask

	task automatic clk_bit(input logic b, output logic r);
		sda_low_o = !b;
		qtr();
		scl_o = 1'b1;
		qtr();
		r = sda_i;
		qtr();
		scl_o = 1'b0;
		qtr();
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
		clk_bit(1'b1, r);
		ack = !r;
	endtask

	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
		clk_bit(last, r);
	endtask
endmodule

`default_nettype wire

// >>> bench/tb_serial_config_port_ref_lock.sv
`timescale 1ns/1ps
`default_nettype none
`include "serial_config_port_ref_lock_cfg.svh"

module tb_serial_config_port_ref_lock;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sel = 1'b0;
	logic [15:0] ferr = 16'h0000;
	logic        scl, m_low, sda_o, oe_n, lk, fine, cmd, rq, harm, loss_of_lock_flag;
	wire logic   sda_w;
	logic [1:0]  rng;
	logic [3:0]  rat;
	logic [7:0]  bq[10];
	int          n_errors = 0;
	int          tests_run = 0;
	int          n_cmd = 0;
	int          n_rq = 0;
	int          fe[5] = '{1200, 600, 200, 600, 1001};
	logic        fl[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

	always #5 clk = !clk;
	// pull-up on the shared data line
	assign sda_w = (m_low || (!oe_n && !sda_o)) ? 1'b0 : 1'b1;

	serial_config_port_ref_lock u_dut (
		.core_clk_i(clk), .reset_n_i(rst_n), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_n_o(oe_n), .address_select_pin_i(sel), .freq_error_ppm_i(ferr),
		.lock_to_ref_o(lk), .fine_meas_en_o(fine), .ref_range_o(rng), .ref_ratio_o(rat),
		.lock_cmd_o(cmd), .reacquire_o(rq), .harmonic_det_en_o(harm),
		.loss_of_lock_flag_o(loss_of_lock_flag)
	);
	two_wire_master_model m (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));

	always @(posedge clk) begin
		if (cmd === 1'b1) n_cmd++;
		if (rq === 1'b1) n_rq++;
	end

	// ==================
	// access tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic snd(input logic [7:0] d, input logic ex);
		logic ak;
		m.wbyte(d, ak);
		chk({7'h00, ak}, {7'h00, ex});
	endtask

	function automatic logic [7:0] adr(input logic rw);
		return {`SLV_ADDR_MSB_VAL, sel, `SLV_ADDR_LOW_VAL, rw};
	endfunction

	task automatic wr(input logic [7:0] s, input int n);
		m.start();
		snd(adr(1'b0), 1'b1);
		snd(s, 1'b1);
		for (int i = 0; i < n; i++) snd(bq[i], 1'b1);
		m.stop();
	endtask

	task automatic rd(input logic [7:0] s, input int n);
		logic [7:0] d;
		m.start();
		snd(adr(1'b0), 1'b1);
		snd(s, 1'b1);
		m.start();
		snd(adr(1'b1), 1'b1);
		for (int i = 0; i < n; i++) begin
			m.rbyte(i == n - 1, d);
			chk(d, bq[i]);
		end
		m.stop();
	endtask

	task automatic final_report();
		if (n_errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#500us;
		n_errors++;
		final_report();
	end

	// ==================
	// tests
	initial begin
		int b;
		logic r;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (10) @(negedge clk);
		chk({5'h00, lk, fine, harm}, 8'h01);
		bq = '{default: 8'h00};
		rd(8'h00, 8);
		for (int i = 0; i < 8; i++) bq[i] = 8'(32 + i);
		wr(8'h02, 6);
		bq[6] = 8'h25;
		bq[7] = 8'h25;
		rd(8'h02, 8);
		for (int p = 0; p < 2; p++) begin
			sel = p[0];
			repeat (4) @(negedge clk);
			m.start();
			snd(adr(1'b0) ^ 8'h40, 1'b0);
			m.start();
			snd(adr(1'b0) | 8'h02, 1'b0);
			m.stop();
			bq[0] = 8'h25;
			rd(8'h07, 1);
		end
		m.start();
		snd(adr(1'b0), 1'b1);
		snd(8'h08, 1'b0);
		snd(8'h99, 1'b0);
		m.stop();
		m.start();
		snd(adr(1'b0), 1'b1);
		snd(8'h03, 1'b1);
		for (int i = 0; i < 7; i++) m.clk_bit(1'b1, r);
		m.stop();
		bq[0] = 8'h21;
		rd(8'h03, 1);
		for (int k = 0; k < 4; k++) begin
			bq[0] = {k[1:0], 4'h5, 2'h0};
			wr(8'h00, 1);
			bq[0][0] = 1'b1;
			wr(8'h00, 1);
			chk({rng, rat, fine, lk}, bq[0]);
			chk({7'h00, harm}, 8'h00);
		end
		chk(8'(n_cmd), 8'h04);
		bq[0] = 8'h3c;
		wr(8'h00, 1);
		chk({4'h0, rat}, {4'h0, `RATIO_MAX});
		bq[0] = 8'h02;
		wr(8'h00, 1);
		chk({5'h00, lk, fine, harm}, 8'h03);
		bq[0] = 8'h01;
		wr(8'h00, 1);
		b = n_rq;
		foreach (fe[i]) begin
			ferr = fe[i][15:0];
			repeat (6) @(negedge clk);
			chk({7'h00, loss_of_lock_flag}, {7'h00, fl[i]});
		end
		chk(8'(n_rq - b), 8'h02);
		final_report();
	end
endmodule

bind serial_config_port_ref_lock
	serial_config_port_ref_lock_sva #(.FREQ_ERR_W(FREQ_ERR_W)) u_sva (
	.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_o(sda_o),
	.sda_oe_n_o(sda_oe_n_o), .freq_error_ppm_i(freq_error_ppm_i),
	.lock_to_ref_o(lock_to_ref_o), .ref_ratio_o(ref_ratio_o), .lock_cmd_o(lock_cmd_o),
	.reacquire_o(reacquire_o), .harmonic_det_en_o(harmonic_det_en_o),
	.loss_of_lock_flag_o(loss_of_lock_flag_o)
);

`default_nettype wire
